// file: pwo_params.svh
// timing counts, command codes and reset values of the oscillator config link
// assumes a 50 MHz core clock on both ends of the link
`ifndef PWO_PARAMS_SVH
`define PWO_PARAMS_SVH
`define PWO_CLK_PERIOD_NS 20
`define PWO_T_ZERO_NS 1000
`define PWO_T_ONE_NS 2500
`define PWO_TOL_PCT 10
`define PWO_T_RESET_NS 30000
`define PWO_T_CBI_NS 50000
`define PWO_T_RSC_NS 1000000
`define PWO_T_RECAL_NS 10000
`define PWO_CYC_MIN(ns) (((ns) + `PWO_CLK_PERIOD_NS - 1) / `PWO_CLK_PERIOD_NS)
`define PWO_PREAMBLE_BITS 7
`define PWO_FRAME_BITS 15
`define PWO_CMD_RUN 8'h50
`define PWO_CMD_STOP 8'h18
`define PWO_CMD_DOZE 8'h20
`define PWO_CMD_SLEEP 8'h30
`define PWO_CMD_FINE 8'h64
`define PWO_CMD_COARSE 8'h72
`define PWO_ARGS_FINE 3'h2
`define PWO_ARGS_COARSE 3'h4
`define PWO_BASE_RESET 32'h2000_0000
`define PWO_OFFSET_SHIFT 25
`endif

// file: pwo_pkg.sv
// types shared by both ends of the oscillator config link
// assumes pwo_params.svh on the include path
`include "pwo_params.svh"
package pwo_pkg;
   typedef enum logic [2:0] {
      PWO_RUN = 3'h0,
      PWO_STOP = 3'h1,
      PWO_DOZE = 3'h2,
      PWO_SLEEP = 3'h3,
      PWO_RECAL = 3'h4
   } pwo_mode_t;

   typedef enum logic [1:0] {
      PWO_H_SETTLE = 2'h0,
      PWO_H_READY = 2'h1,
      PWO_H_BITS = 2'h2,
      PWO_H_GAP = 2'h3
   } pwo_host_state_t;

   function automatic logic [2:0] pwo_arg_count(input logic [7:0] code);
      if (code == `PWO_CMD_FINE) begin
         return `PWO_ARGS_FINE;
      end else if (code == `PWO_CMD_COARSE) begin
         return `PWO_ARGS_COARSE;
      end
      return 3'h0;
   endfunction
endpackage

// file: pwo_link_if.sv
// the single config wire between host and oscillator
// assumes the testbench instances it and hands one modport to each end
`timescale 1ns/1ps
interface pwo_link_if;
   logic hostOut;
   logic hostOe_n;
   logic pullUpOn;
   logic line;

   // device pull-up wins whenever the host releases the wire
   assign line = !hostOe_n ? hostOut : pullUpOn;

   modport device (input line, output pullUpOn);
   modport host (output hostOut, output hostOe_n);
endinterface

// file: pwo_device_end.sv
// oscillator end: wire receiver, command assembly, mode sequencer, clock output
// assumes the wire is asynchronous to core_clk and the host keeps its timing
`timescale 1ns/1ps
`include "pwo_params.svh"

// How it works
// - device pull-up keeps wire high when released
// - host drives low itself for low idle
// - host holds wire quiet after idle change
// - transactions start and end at idle
// - short interval zero, long interval one
// - accept intervals within ten percent window
// - host one interval at least 2.5x zero
// - quiet wire mid-frame aborts, drops bits
// - power-up in Run with factory configuration
// - commands change state, mode, frequency
// - fine offset steps of 29.8 ppb
// - fine offset applied without glitch
// - coarse retune blanks output cleanly
// - four output states Run Stop Doze Sleep
// - finish current cycle, then high impedance
// - Stop disables only the output driver
// - Doze also stops loop and resonator
// - Sleep keeps only retained configuration
// - frame is seven zeros then eight bits
// - data field sent least significant first
// - host settles link before first command
// - command byte plus zero to four args
module pwo_device_end
   import pwo_pkg::*;
#(
   parameter int T_ZERO_NS = `PWO_T_ZERO_NS,
   parameter int T_ONE_NS = `PWO_T_ONE_NS,
   parameter int T_RESET_NS = `PWO_T_RESET_NS,
   parameter int T_RECAL_NS = `PWO_T_RECAL_NS,
   parameter logic [31:0] BASE_RESET = `PWO_BASE_RESET
) (
   input wire logic core_clk, // 50 MHz core clock
   input wire logic rst_n, // synchronous reset, active low
   pwo_link_if.device link, // config wire
   output logic clkOut, // generated output clock
   output logic clkOe_n, // output driver enable, low drives
   output logic coreOn, // digital core powered
   output logic resonatorOn, // resonator and loop running
   output logic retainOn, // retention storage powered
   output logic [2:0] modeState, // current output state
   output logic cmdExec, // pulse: command executed
   output logic [7:0] lastCmd // code of last executed command
);
   localparam int CLK_NS = `PWO_CLK_PERIOD_NS;
   localparam int TOL = `PWO_TOL_PCT;
   localparam int ZERO_LO = (T_ZERO_NS * (100 - TOL) + 100 * CLK_NS - 1) / (100 * CLK_NS);
   localparam int ZERO_HI = (T_ZERO_NS * (100 + TOL)) / (100 * CLK_NS);
   localparam int ONE_LO = (T_ONE_NS * (100 - TOL) + 100 * CLK_NS - 1) / (100 * CLK_NS);
   localparam int ONE_HI = (T_ONE_NS * (100 + TOL)) / (100 * CLK_NS);
   localparam int RESET_CYC = `PWO_CYC_MIN(T_RESET_NS);
   localparam int RECAL_CYC = `PWO_CYC_MIN(T_RECAL_NS);
   localparam logic [3:0] LAST_BIT = 4'(`PWO_FRAME_BITS - 1);
   localparam logic [3:0] PRE_BITS = 4'(`PWO_PREAMBLE_BITS);

   logic s1, s2, prevLine, lineEdge;
   logic [15:0] quietCnt, intervalLen;
   logic steadyHit, bitZero, bitOne, bitOk;
   logic armed, idleLevel, inFrame, byteStrobe, frameAbort;
   logic [3:0] bitCnt;
   logic [7:0] shiftReg;
   logic pending, execStrobe;
   logic [2:0] argNeed;
   logic [1:0] argIdx;
   logic [7:0] cmdCode;
   logic [31:0] argWord;
   pwo_mode_t mode, reqMode;
   logic [31:0] baseWord, pendingBase, acc, incr, accNext;
   logic signed [15:0] fineOffset;
   logic signed [48:0] offProd;
   logic [23:0] offDelta;
   logic [15:0] recalCnt;
   logic riseNext, leaveRun;

   ////////////////////////////////////////////////////////////////////////////
   // wire receiver

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link.pullUpOn <= 1'b1;
      end else begin
         link.pullUpOn <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         prevLine <= 1'b1;
      end else begin
         s1 <= link.line;
         s2 <= s1;
         prevLine <= s2;
      end
   end

   assign lineEdge = s2 ^ prevLine;
   assign intervalLen = quietCnt + 16'h0001;
   assign steadyHit = !lineEdge && (quietCnt == 16'(RESET_CYC - 1));
   assign bitZero = intervalLen >= 16'(ZERO_LO) && intervalLen <= 16'(ZERO_HI);
   assign bitOne = intervalLen >= 16'(ONE_LO) && intervalLen <= 16'(ONE_HI);
   assign bitOk = bitZero || bitOne;

   // saturating count since the last edge; doubles as the interval meter
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         quietCnt <= 16'h0000;
      end else if (lineEdge) begin
         quietCnt <= 16'h0000;
      end else if (quietCnt != 16'(RESET_CYC)) begin
         quietCnt <= quietCnt + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         armed <= 1'b0;
         idleLevel <= 1'b1;
         inFrame <= 1'b0;
         bitCnt <= 4'h0;
         shiftReg <= 8'h00;
         byteStrobe <= 1'b0;
         frameAbort <= 1'b0;
      end else begin
         byteStrobe <= 1'b0;
         frameAbort <= 1'b0;
         if (steadyHit) begin
            // quiet wire marks the idle level, whichever polarity the host picked
            armed <= 1'b1;
            idleLevel <= s2;
            inFrame <= 1'b0;
            if (inFrame || s2 != idleLevel) begin
               frameAbort <= 1'b1;
            end
         end else if (lineEdge) begin
            if (mode == PWO_SLEEP) begin
               armed <= 1'b0;
            end else if (!inFrame) begin
               if (armed && s2 != idleLevel) begin
                  inFrame <= 1'b1;
                  bitCnt <= 4'h0;
               end else begin
                  armed <= 1'b0;
               end
            end else if (!bitOk || (bitCnt < PRE_BITS && bitOne)) begin
               // bad interval or nonzero preamble: wait for quiet before next frame
               inFrame <= 1'b0;
               frameAbort <= 1'b1;
               armed <= 1'b0;
            end else begin
               shiftReg <= {bitOne, shiftReg[7:1]};
               bitCnt <= bitCnt + 4'h1;
               if (bitCnt == LAST_BIT) begin
                  inFrame <= 1'b0;
                  byteStrobe <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // command assembly

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pending <= 1'b0;
         argNeed <= 3'h0;
         argIdx <= 2'h0;
         cmdCode <= 8'h00;
         argWord <= 32'h0000_0000;
         execStrobe <= 1'b0;
      end else begin
         execStrobe <= 1'b0;
         if (frameAbort) begin
            pending <= 1'b0;
         end else if (byteStrobe) begin
            if (!pending) begin
               cmdCode <= shiftReg;
               argWord <= 32'h0000_0000;
               argIdx <= 2'h0;
               argNeed <= pwo_arg_count(shiftReg);
               if (pwo_arg_count(shiftReg) == 3'h0) begin
                  execStrobe <= 1'b1;
               end else begin
                  pending <= 1'b1;
               end
            end else begin
               argWord[{argIdx, 3'b000} +: 8] <= shiftReg;
               argIdx <= argIdx + 2'h1;
               if ({1'b0, argIdx} + 3'h1 == argNeed) begin
                  pending <= 1'b0;
                  execStrobe <= 1'b1;
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencer

   // offset lsb is base/2^25, one step of about 29.8 ppb
   assign offProd = $signed({1'b0, baseWord}) * fineOffset;
   assign offDelta = offProd[48:`PWO_OFFSET_SHIFT];
   assign incr = baseWord + {{8{offDelta[23]}}, offDelta};
   assign accNext = acc + incr;
   assign riseNext = !acc[31] && accNext[31];
   assign leaveRun = reqMode != PWO_RUN && riseNext && !execStrobe;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode <= PWO_RUN;
         reqMode <= PWO_RUN;
         baseWord <= BASE_RESET;
         pendingBase <= BASE_RESET;
         fineOffset <= 16'sh0000;
         recalCnt <= 16'h0000;
      end else if (execStrobe && mode != PWO_SLEEP && mode != PWO_RECAL) begin
         case (cmdCode)
            `PWO_CMD_RUN: begin
               reqMode <= PWO_RUN;
               if (mode == PWO_STOP) begin
                  mode <= PWO_RUN;
               end else if (mode != PWO_RUN) begin
                  mode <= PWO_RECAL;
                  pendingBase <= baseWord;
                  recalCnt <= 16'h0000;
               end
            end
            `PWO_CMD_STOP, `PWO_CMD_DOZE, `PWO_CMD_SLEEP: begin
               if (mode == PWO_RUN) begin
                  reqMode <= (cmdCode == `PWO_CMD_STOP) ? PWO_STOP :
                             (cmdCode == `PWO_CMD_DOZE) ? PWO_DOZE : PWO_SLEEP;
               end else begin
                  mode <= (cmdCode == `PWO_CMD_STOP) ? PWO_STOP :
                          (cmdCode == `PWO_CMD_DOZE) ? PWO_DOZE : PWO_SLEEP;
               end
            end
            `PWO_CMD_FINE: begin
               fineOffset <= argWord[15:0];
            end
            `PWO_CMD_COARSE: begin
               pendingBase <= argWord;
               if (mode == PWO_RUN) begin
                  reqMode <= PWO_RECAL;
               end else begin
                  baseWord <= argWord;
               end
            end
            default: begin
            end
         endcase
      end else if (mode == PWO_RUN && leaveRun) begin
         mode <= reqMode;
         recalCnt <= 16'h0000;
      end else if (mode == PWO_RECAL) begin
         if (recalCnt == 16'(RECAL_CYC - 1)) begin
            mode <= PWO_RUN;
            reqMode <= PWO_RUN;
            baseWord <= pendingBase;
         end else begin
            recalCnt <= recalCnt + 16'h0001;
         end
      end else if (mode == PWO_SLEEP && lineEdge) begin
         // any edge wakes; retained config is restarted through recalibration
         mode <= PWO_RECAL;
         pendingBase <= baseWord;
         recalCnt <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock output and power

   // restarts from phase zero so the first high half is always whole
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         acc <= 32'h0000_0000;
         clkOut <= 1'b0;
         clkOe_n <= 1'b1;
      end else if (mode == PWO_RUN && !leaveRun) begin
         acc <= accNext;
         clkOut <= accNext[31];
         clkOe_n <= 1'b0;
      end else begin
         acc <= 32'h0000_0000;
         clkOut <= 1'b0;
         clkOe_n <= 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         coreOn <= 1'b1;
         resonatorOn <= 1'b1;
         retainOn <= 1'b1;
         modeState <= 3'h0;
         cmdExec <= 1'b0;
         lastCmd <= 8'h00;
      end else begin
         coreOn <= mode != PWO_SLEEP;
         resonatorOn <= mode == PWO_RUN || mode == PWO_STOP || mode == PWO_RECAL;
         retainOn <= 1'b1;
         modeState <= mode;
         cmdExec <= execStrobe;
         if (execStrobe) begin
            lastCmd <= cmdCode;
         end
      end
   end
endmodule

// file: pwo_host_end.sv
// host end: turns user bytes into interval-coded frames on the config wire
// assumes user logic on core_clk; command boundaries are the user's business
`timescale 1ns/1ps
`include "pwo_params.svh"
module pwo_host_end
   import pwo_pkg::*;
#(
   parameter int T_ZERO_NS = `PWO_T_ZERO_NS,
   parameter int T_ONE_NS = `PWO_T_ONE_NS,
   parameter int T_CBI_NS = `PWO_T_CBI_NS,
   parameter int SETTLE_CYC = `PWO_CYC_MIN(`PWO_T_RSC_NS)
) (
   input wire logic core_clk, // 50 MHz core clock
   input wire logic rst_n, // synchronous reset, active low
   pwo_link_if.host link, // config wire
   input wire logic byteValid, // user byte offered
   input wire logic [7:0] byteData, // byte to send
   input wire logic idleLow, // select low idle level
   output logic byteReady // ready to take a byte
);
   localparam int ZERO_CYC = `PWO_CYC_MIN(T_ZERO_NS);
   // one interval kept at least 2.5 zero intervals by the defaults
   localparam int ONE_CYC = `PWO_CYC_MIN(T_ONE_NS);
   localparam int GAP_CYC = `PWO_CYC_MIN(T_CBI_NS);
   localparam logic [3:0] LAST_BIT = 4'(`PWO_FRAME_BITS - 1);

   pwo_host_state_t st;
   logic [19:0] cnt, curLen;
   logic [14:0] frame;
   logic [3:0] bitIdx;
   logic level, idleLevel;

   assign curLen = frame[0] ? 20'(ONE_CYC) : 20'(ZERO_CYC);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st <= PWO_H_SETTLE;
         cnt <= 20'h00000;
         frame <= 15'h0000;
         bitIdx <= 4'h0;
         level <= 1'b1;
         idleLevel <= 1'b1;
         byteReady <= 1'b0;
      end else begin
         unique case (st)
            PWO_H_SETTLE: begin
               // quiet hold after reset or idle change, before any frame
               if (cnt == 20'(SETTLE_CYC - 1)) begin
                  st <= PWO_H_READY;
                  cnt <= 20'h00000;
                  byteReady <= 1'b1;
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
            PWO_H_READY: begin
               if (byteValid) begin
                  frame <= {byteData, 7'h00};
                  level <= ~idleLevel;
                  bitIdx <= 4'h0;
                  cnt <= 20'h00000;
                  st <= PWO_H_BITS;
                  byteReady <= 1'b0;
               end else if (idleLow == idleLevel) begin
                  idleLevel <= ~idleLow;
                  level <= ~idleLow;
                  cnt <= 20'h00000;
                  st <= PWO_H_SETTLE;
                  byteReady <= 1'b0;
               end
            end
            PWO_H_BITS: begin
               if (cnt == curLen - 20'h00001) begin
                  level <= ~level;
                  cnt <= 20'h00000;
                  frame <= {1'b0, frame[14:1]};
                  bitIdx <= bitIdx + 4'h1;
                  if (bitIdx == LAST_BIT) begin
                     st <= PWO_H_GAP;
                  end
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
            PWO_H_GAP: begin
               if (cnt == 20'(GAP_CYC - 1)) begin
                  st <= PWO_H_READY;
                  cnt <= 20'h00000;
                  byteReady <= 1'b1;
               end else begin
                  cnt <= cnt + 20'h00001;
               end
            end
         endcase
      end
   end

   // drive low actively, release for high and let the pull-up act
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         link.hostOut <= 1'b0;
         link.hostOe_n <= 1'b1;
      end else begin
         link.hostOut <= 1'b0;
         link.hostOe_n <= level;
      end
   end
endmodule

// file: pwo_link_assertions.sv
// wire-level checks of the oscillator config link
// assumes one host end and one device end share the watched wire
`timescale 1ns/1ps
module pwo_link_assertions (
   input wire logic core_clk, // core clock
   input wire logic rst_n, // synchronous reset, active low
   input wire logic hostOut, // host drive value
   input wire logic hostOe_n, // host drive enable, low drives
   input wire logic pullUpOn, // device pull-up
   input wire logic line // resolved wire
);
   localparam int QUIET = 1500;
   logic [11:0] quiet;
   logic [4:0] burstEdges;
   logic prevLine;
   logic startLevel;
   logic edgeSeen;
   assign edgeSeen = line != prevLine;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      prevLine <= line;
   end
   // saturate high after reset so a fresh idle change is not read as a short interval
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         quiet <= 12'hFFF;
      end else if (edgeSeen) begin
         quiet <= 12'h001;
      end else if (quiet != 12'hFFF) begin
         quiet <= quiet + 12'h001;
      end
   end
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         burstEdges <= 5'h00;
      end else if (edgeSeen) begin
         burstEdges <= (quiet >= QUIET) ? 5'h01 : burstEdges + 5'h01;
      end
   end
   always_ff @(posedge core_clk) begin
      if (edgeSeen && quiet >= QUIET) begin
         startLevel <= prevLine;
      end
   end
   ////////////////////////////////////////
   chk_pullup_held: assert property (pullUpOn)
      else $error("device pull-up released");
   chk_idle_after_reset: assert property ($rose(rst_n) |-> line)
      else $error("wire not high after reset");
   chk_host_drives_low: assert property (!hostOe_n |-> !hostOut)
      else $error("host drives the wire high");
   chk_interval_window: assert property (edgeSeen && quiet < QUIET |->
      (quiet >= 45 && quiet <= 55) || (quiet >= 113 && quiet <= 137))
      else $error("interval outside both bit windows");
   chk_preamble_zeros: assert property (edgeSeen && quiet < QUIET && burstEdges <= 7 |->
      quiet <= 55)
      else $error("preamble bit is not a zero");
   chk_burst_edge_count: assert property (quiet == 12'h5DC |->
      burstEdges == 5'h01 || burstEdges == 5'h10)
      else $error("burst is neither an idle change nor one frame");
   chk_level_restored: assert property (quiet == 12'h5DC && burstEdges == 5'h10 |->
      line == startLevel)
      else $error("frame did not end at its idle level");
   chk_edge_spacing: assert property (edgeSeen |=> !edgeSeen [*8])
      else $error("wire edges too close together");
   cover property (quiet == 12'h5DC && burstEdges == 5'h01);
   cover property (quiet == 12'h5DC && burstEdges == 5'h10 && !line);
   cover property (edgeSeen && quiet >= 113 && quiet < QUIET);
endmodule

// file: test_pulse_width_osc_config_link.sv
// self-checking bench: host end and device end on one wire, a bench-driven wire on a second
// assumes pwo_params.svh on the include path and the design files compiled before it
`timescale 1ns/1ps
`include "pwo_params.svh"
module test_pulse_width_osc_config_link
   import pwo_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic byteValid = 1'b0;
   logic [7:0] byteData = 8'h00;
   logic idleLow = 1'b0;
   logic byteReady, clkOut, clkOe_n, coreOn, resonatorOn, retainOn, cmdExec, cmdExec2;
   logic [2:0] modeState;
   logic [7:0] lastCmd, lastCmd2;
   logic prevOe = 1'b1;
   logic prevClk = 1'b0;
   logic wPrev = 1'b1;
   logic [14:0] wSh = 15'h0000;
   logic [7:0] sentQ[$];
   int n_mismatch = 0;
   int num_checks = 0;
   int nExec = 0;
   int nExec2 = 0;
   int nOff = 0;
   int wCnt = 4000;
   int wBits = 0;
   pwo_link_if link();
   pwo_link_if link2();
   always #10 core_clk = ~core_clk;
   // shorter byte gap keeps the run short; still above the abort time
   pwo_host_end #(.T_CBI_NS(32000), .SETTLE_CYC(1600)) i_pwo_host_end (.core_clk(core_clk),
      .rst_n(rst_n), .link(link.host), .byteValid(byteValid), .byteData(byteData),
      .idleLow(idleLow), .byteReady(byteReady));
   pwo_device_end i_pwo_device_end (.core_clk(core_clk), .rst_n(rst_n), .link(link.device),
      .clkOut(clkOut), .clkOe_n(clkOe_n), .coreOn(coreOn), .resonatorOn(resonatorOn),
      .retainOn(retainOn), .modeState(modeState), .cmdExec(cmdExec), .lastCmd(lastCmd));
   pwo_device_end i_pwo_device_end_2 (.core_clk(core_clk), .rst_n(rst_n), .link(link2.device),
      .clkOut(), .clkOe_n(), .coreOn(), .resonatorOn(), .retainOn(), .modeState(),
      .cmdExec(cmdExec2), .lastCmd(lastCmd2));
   pwo_link_assertions i_pwo_link_assertions (.core_clk(core_clk), .rst_n(rst_n),
      .hostOut(link.hostOut), .hostOe_n(link.hostOe_n), .pullUpOn(link.pullUpOn),
      .line(link.line));
   ////////////////////////////////////////
   task automatic check_bit(input logic act, input logic exp);
      num_checks++;
      if (act !== exp) begin
         n_mismatch++;
         $display("Error at %0t: flag %b, expected %b", $time, act, exp);
      end
   endtask
   task automatic check_byte(input logic [7:0] act, input logic [7:0] exp);
      num_checks++;
      if (act !== exp) begin
         n_mismatch++;
         $display("Error at %0t: value %h, expected %h", $time, act, exp);
      end
   endtask
   task automatic check_num(input int act, input int exp);
      num_checks++;
      if (act != exp) begin
         n_mismatch++;
         $display("Error at %0t: count %0d, expected %0d", $time, act, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   ////////////////////////////////////////
   always @(negedge core_clk) begin
      if (cmdExec === 1'b1) nExec++;
      if (cmdExec2 === 1'b1) nExec2++;
      if (rst_n === 1'b1 && prevOe === 1'b0 && clkOe_n === 1'b1) begin
         nOff++;
         check_bit(prevClk, 1'b0);
         check_bit(clkOut, 1'b0);
      end
      prevOe = clkOe_n;
      prevClk = clkOut;
   end
   // decodes the host wire independently of the device
   always @(negedge core_clk) begin
      if (link.line !== wPrev) begin
         if (wCnt < 1500) begin
            wSh = {wCnt > 90, wSh[14:1]};
            wBits++;
         end
         wCnt = 0;
      end else if (wCnt < 4000) begin
         wCnt++;
      end
      if (wCnt == 1500) wBits = 0;
      if (wBits == 15) begin
         check_byte({1'b0, wSh[6:0]}, 8'h00);
         check_byte(wSh[14:7], sentQ.pop_front());
         wBits = 0;
      end
      wPrev = link.line;
   end
   ////////////////////////////////////////
   task automatic wait_ready();
      int n;
      n = 0;
      while (byteReady !== 1'b1 && n < 9000) begin
         @(negedge core_clk);
         n++;
      end
      check_bit(byteReady, 1'b1);
   endtask
   task automatic send_byte(input logic [7:0] b);
      wait_ready();
      sentQ.push_back(b);
      byteData = b;
      byteValid = 1'b1;
      @(negedge core_clk);
      byteValid = 1'b0;
   endtask
   task automatic send_cmd(input logic [7:0] code, input int nArg, input logic [31:0] arg,
      input int expExec);
      send_byte(code);
      for (int i = 0; i < nArg; i++) begin
         send_byte(arg[8*i +: 8]);
         check_num(nExec, expExec - 1);
      end
      wait_ready();
      check_num(nExec, expExec);
   endtask
   task automatic count_rises(input int cyc, input int exp);
      int r;
      logic p;
      r = 0;
      p = clkOut;
      repeat (cyc) begin
         @(negedge core_clk);
         if (p === 1'b0 && clkOut === 1'b1) r++;
         p = clkOut;
      end
      check_num(r, exp);
   endtask
   task automatic check_state(input pwo_mode_t m, input logic oe_n, input logic res,
      input logic core);
      check_byte({5'h00, modeState}, {5'h00, m});
      check_bit(clkOe_n, oe_n);
      check_bit(resonatorOn, res);
      check_bit(coreOn, core);
      check_bit(retainOn, 1'b1);
   endtask
   // bench plays host on the second wire, breaking timing where asked
   task automatic wire_frame(input logic [7:0] b, input int zl, input int ol, input int badAt,
      input int stopAt);
      logic [14:0] f;
      logic lvl;
      f = {b, 7'h00};
      lvl = 1'b1;
      for (int i = 0; i < stopAt; i++) begin
         lvl = !lvl;
         link2.hostOe_n = lvl;
         repeat (i == badAt ? 70 : (f[i] ? ol : zl)) @(negedge core_clk);
      end
      link2.hostOe_n = 1'b1;
      repeat (1700) @(negedge core_clk);
   endtask
   ////////////////////////////////////////
   task automatic power_up_run();
      repeat (3) @(negedge core_clk);
      check_state(PWO_RUN, 1'b0, 1'b1, 1'b1);
      check_bit(link.line, 1'b1);
      check_byte(lastCmd, 8'h00);
      count_rises(2048, 256);
   endtask
   task automatic stop_and_doze();
      send_cmd(`PWO_CMD_STOP, 0, 32'h0, 1);
      check_byte(lastCmd, `PWO_CMD_STOP);
      check_state(PWO_STOP, 1'b1, 1'b1, 1'b1);
      send_cmd(`PWO_CMD_RUN, 0, 32'h0, 2);
      check_state(PWO_RUN, 1'b0, 1'b1, 1'b1);
      send_cmd(`PWO_CMD_DOZE, 0, 32'h0, 3);
      check_state(PWO_DOZE, 1'b1, 1'b0, 1'b1);
      send_cmd(`PWO_CMD_RUN, 0, 32'h0, 4);
      check_state(PWO_RUN, 1'b0, 1'b1, 1'b1);
   endtask
   task automatic retune_and_offset();
      int k;
      send_cmd(`PWO_CMD_COARSE, 4, 32'h4000_0000, 5);
      check_byte(lastCmd, `PWO_CMD_COARSE);
      check_state(PWO_RUN, 1'b0, 1'b1, 1'b1);
      count_rises(4096, 1024);
      k = nOff;
      send_cmd(`PWO_CMD_FINE, 2, 32'h0000_8000, 6);
      check_num(nOff, k);
      count_rises(4096, 1023);
   endtask
   task automatic sleep_and_wake();
      send_cmd(`PWO_CMD_SLEEP, 0, 32'h0, 7);
      check_state(PWO_SLEEP, 1'b1, 1'b0, 1'b0);
      send_cmd(`PWO_CMD_RUN, 0, 32'h0, 7);
      check_byte(lastCmd, `PWO_CMD_SLEEP);
      check_state(PWO_RUN, 1'b0, 1'b1, 1'b1);
      count_rises(4096, 1023);
   endtask
   task automatic low_idle_frame();
      idleLow = 1'b1;
      repeat (1700) @(negedge core_clk);
      check_bit(link.line, 1'b0);
      send_cmd(`PWO_CMD_STOP, 0, 32'h0, 8);
      check_state(PWO_STOP, 1'b1, 1'b1, 1'b1);
      check_bit(link.line, 1'b0);
      send_cmd(`PWO_CMD_RUN, 0, 32'h0, 9);
      idleLow = 1'b0;
      repeat (1700) @(negedge core_clk);
      check_bit(link.line, 1'b1);
   endtask
   task automatic wire_faults();
      wire_frame(`PWO_CMD_STOP, 45, 137, -1, 15);
      check_byte(lastCmd2, `PWO_CMD_STOP);
      wire_frame(`PWO_CMD_RUN, 55, 113, -1, 15);
      check_num(nExec2, 2);
      wire_frame(`PWO_CMD_FINE, 50, 125, -1, 15);
      wire_frame(8'hA5, 50, 125, -1, 10);
      wire_frame(`PWO_CMD_DOZE, 50, 125, -1, 15);
      check_num(nExec2, 3);
      check_byte(lastCmd2, `PWO_CMD_DOZE);
      wire_frame(`PWO_CMD_STOP, 50, 125, 3, 15);
      check_num(nExec2, 3);
      wire_frame(`PWO_CMD_RUN, 50, 125, -1, 15);
      check_byte(lastCmd2, `PWO_CMD_RUN);
   endtask
   ////////////////////////////////////////
   // the scenarios need about 76k cycles
   initial begin
      repeat (95000) @(posedge core_clk);
      n_mismatch++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end
   initial begin
      link2.hostOut = 1'b0;
      link2.hostOe_n = 1'b1;
      repeat (4) @(negedge core_clk);
      rst_n = 1'b1;
      power_up_run();
      stop_and_doze();
      retune_and_offset();
      sleep_and_wake();
      low_idle_frame();
      wire_faults();
      tally_and_finish();
   end
endmodule
